// ==== logic/spimsp_port.sv ====
// full duplex double buffered serial port, master or slave, with apb registers
`timescale 1ns/1ps
module spimsp_port (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [spimsp_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  output logic      [31:0]                     prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  input  wire logic                            sclk_i,
  output logic                                 sclk_o,
  output logic                                 sclk_oe_o,
  input  wire logic                            mosi_i,
  output logic                                 mosi_o,
  output logic                                 mosi_oe_o,
  input  wire logic                            miso_i,
  output logic                                 miso_o,
  output logic                                 miso_oe_o,
  input  wire logic                            sel_n_i,
  output logic                                 sel_n_o,
  output logic                                 sel_oe_o,
  output logic                                 irq_o
);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // half period of sclk in core cycles, minus one, for a rate code
  function automatic logic [5:0] half_len(input logic [1:0] rate);
    half_len = 6'(spimsp_pkg::HALF_BASE << rate) - 6'h01;
  endfunction : half_len

  // byte address decode of a register index
  function automatic logic addr_hit(input logic [spimsp_pkg::ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    addr_hit = (a == {idx, 2'b00});
  endfunction : addr_hit

  logic [7:0]                cfg_one_q;
  logic [7:0]                cfg_two_q;
  logic                      owner_q;
  logic [7:0]                tx_hold_q;
  logic                      tx_full_q;
  logic [7:0]                rx_hold_q;
  logic                      rx_full_q;
  logic                      rx_fresh_q;
  logic                      ovf_q;
  logic [7:0]                sh_q;
  logic                      in_bit_q;
  logic [2:0]                cnt_q;
  logic                      loaded_q;
  logic [5:0]                hc_q;
  logic [3:0]                stall_q;
  logic                      sclk_q;
  logic                      rdy_q;
  logic [31:0]               prdata_q;
  logic [3:0]                sync1_q;
  logic [3:0]                sync2_q;
  logic [3:0]                sync3_q;
  spimsp_pkg::spimsp_state_t state_q;

  // config fields
  wire en        = cfg_two_q[spimsp_pkg::C2_ENABLE] & ~owner_q;
  wire master    = cfg_two_q[spimsp_pkg::C2_MASTER];
  wire cont      = cfg_two_q[spimsp_pkg::C2_CONT];
  wire irq_mode  = cfg_one_q[spimsp_pkg::C1_IRQ_MODE];
  wire auto_sel  = cfg_one_q[spimsp_pkg::C1_AUTO_SEL];
  wire sel_in_en = cfg_one_q[spimsp_pkg::C1_SEL_IN_EN];
  wire ovf_write = cfg_one_q[spimsp_pkg::C1_OVF_WRITE];
  wire [1:0] rate = cfg_one_q[spimsp_pkg::C1_RATE_HI:spimsp_pkg::C1_RATE_LO];

  // synchronised pins: {sel_n, sclk, mosi, miso}
  wire miso_s  = sync2_q[0];
  wire mosi_s  = sync2_q[1];
  wire sclk_s  = sync2_q[2];
  wire sel_n_s = sync2_q[3];
  wire sclk_p  = sync3_q[2];

  // two flip-flop synchronisers, third stage only for edge detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
      sync3_q <= 4'hf;
    end else begin
      sync1_q <= {sel_n_i, sclk_i, mosi_i, miso_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // apb decode
  wire acc     = psel_i & penable_i;
  wire done_ap = acc & rdy_q;
  wire wr      = done_ap & pwrite_i;
  wire rd      = done_ap & ~pwrite_i;
  wire hit_tx  = addr_hit(paddr_i, spimsp_pkg::IDX_TX_BUF);
  wire hit_rx  = addr_hit(paddr_i, spimsp_pkg::IDX_RX_BUF);
  wire hit_c1  = addr_hit(paddr_i, spimsp_pkg::IDX_CFG_ONE);
  wire hit_c2  = addr_hit(paddr_i, spimsp_pkg::IDX_CFG_TWO);
  wire hit_st  = addr_hit(paddr_i, spimsp_pkg::IDX_IRQ_STAT);
  wire hit_own = addr_hit(paddr_i, spimsp_pkg::IDX_PIN_OWNER);
  wire mapped  = hit_tx | hit_rx | hit_c1 | hit_c2 | hit_st | hit_own;
  wire capture = acc & ~rdy_q;

  // modes and edges of the serial clock
  wire m_act   = en & master;
  wire s_act   = en & ~master & (~sel_in_en | ~sel_n_s);
  wire tick    = (hc_q == spimsp_pkg::HALF_ZERO);
  wire in_shift = (state_q == spimsp_pkg::SPIMSP_SHIFT);
  wire m_rise  = in_shift & tick & ~sclk_q;
  wire m_fall  = in_shift & tick & sclk_q;
  wire rise    = m_act ? m_rise : (s_act & sclk_s & ~sclk_p);
  wire fall    = m_act ? m_fall : (s_act & ~sclk_s & sclk_p);
  wire samp    = m_act ? miso_s : mosi_s;
  wire byte_done = fall & (cnt_q == spimsp_pkg::LAST_BIT);
  wire [7:0] rx_byte = {sh_q[6:0], in_bit_q};

  // buffer moves
  wire m_start = m_act & (state_q == spimsp_pkg::SPIMSP_IDLE) & tx_full_q;
  wire m_next  = m_act & byte_done & cont & tx_full_q;
  wire s_load  = s_act & (cnt_q == spimsp_pkg::FIRST_BIT) & ~sclk_s & ~loaded_q & tx_full_q;
  wire take    = m_start | m_next | s_load;
  wire deliver = byte_done & (~rx_full_q | ovf_write);
  wire drop    = byte_done & rx_full_q;
  wire pop     = rd & hit_rx & ~rx_fresh_q & ~deliver;

  // status and interrupt view
  wire irq_cond = en & (irq_mode ? ~tx_full_q : rx_full_q);
  wire [7:0] stat_v = 8'({irq_cond, ovf_q, ~(state_q == spimsp_pkg::SPIMSP_IDLE),
                          ~tx_full_q, rx_full_q});

  // read mux, tx buffer is write only
  wire [7:0] rd_mux = hit_rx  ? rx_hold_q :
                      hit_c1  ? cfg_one_q :
                      hit_c2  ? cfg_two_q :
                      hit_st  ? stat_v :
                      hit_own ? 8'({owner_q}) : spimsp_pkg::BYTE_ZERO;

  // apb slave: one wait state, read data captured in the first access cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_q    <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      rdy_q <= acc & ~rdy_q;
      if (capture) begin
        prdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // software registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_one_q <= spimsp_pkg::CFG_ONE_RST;
      cfg_two_q <= spimsp_pkg::CFG_TWO_RST;
      owner_q   <= 1'b0;
    end else if (wr) begin
      if (hit_c1) cfg_one_q <= pwdata_i[7:0];
      if (hit_c2) cfg_two_q <= pwdata_i[7:0];
      if (hit_own) owner_q <= pwdata_i[spimsp_pkg::OWN_I2C];
    end
  end

  // transmit holding buffer, a write wins over a take in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_hold_q <= spimsp_pkg::BYTE_ZERO;
      tx_full_q <= 1'b0;
    end else if (wr && hit_tx) begin
      tx_hold_q <= pwdata_i[7:0];
      tx_full_q <= 1'b1;
    end else if (take) begin
      tx_full_q <= 1'b0;
    end
  end

  // receive holding buffer and overflow flag, set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_hold_q  <= spimsp_pkg::BYTE_ZERO;
      rx_full_q  <= 1'b0;
      rx_fresh_q <= 1'b0;
      ovf_q      <= 1'b0;
    end else begin
      if (deliver) begin
        rx_hold_q <= rx_byte;
      end
      rx_full_q  <= deliver | (rx_full_q & ~pop);
      rx_fresh_q <= deliver | (rx_fresh_q & ~capture);
      ovf_q      <= drop | (ovf_q & ~(wr & hit_st & pwdata_i[spimsp_pkg::ST_OVERFLOW]));
    end
  end

  // shift register, bit counter and slave preload
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q     <= spimsp_pkg::BYTE_ZERO;
      in_bit_q <= 1'b0;
      cnt_q    <= spimsp_pkg::FIRST_BIT;
      loaded_q <= 1'b0;
    end else if (!(m_act || s_act)) begin
      cnt_q    <= spimsp_pkg::FIRST_BIT;
      loaded_q <= 1'b0;
    end else begin
      if (rise) in_bit_q <= samp;
      if (take) begin
        sh_q <= tx_hold_q;
      end else if (fall) begin
        sh_q <= rx_byte;
      end
      if (m_start) begin
        cnt_q <= spimsp_pkg::FIRST_BIT;
      end else if (fall) begin
        cnt_q <= cnt_q + 3'h1;
      end
      loaded_q <= s_load | (loaded_q & ~byte_done);
    end
  end

  // master sequencer and clock divider
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= spimsp_pkg::SPIMSP_IDLE;
      hc_q    <= spimsp_pkg::HALF_ZERO;
      stall_q <= 4'h0;
      sclk_q  <= 1'b0;
    end else if (!m_act) begin
      state_q <= spimsp_pkg::SPIMSP_IDLE;
      sclk_q  <= 1'b0;
      hc_q    <= spimsp_pkg::HALF_ZERO;
    end else begin
      hc_q <= tick ? half_len(rate) : hc_q - 6'h01;
      case (state_q)
        spimsp_pkg::SPIMSP_IDLE: begin
          sclk_q <= 1'b0;
          if (m_start) begin
            state_q <= spimsp_pkg::SPIMSP_SHIFT;
            hc_q    <= half_len(rate);
          end
        end
        spimsp_pkg::SPIMSP_SHIFT: begin
          if (tick) sclk_q <= ~sclk_q;
          if (byte_done && !m_next) begin
            state_q <= spimsp_pkg::SPIMSP_STALL;
            stall_q <= spimsp_pkg::STALL_HALVES;
          end
        end
        spimsp_pkg::SPIMSP_STALL: begin
          if (tick) begin
            stall_q <= stall_q - 4'h1;
            if (stall_q == 4'h1) state_q <= spimsp_pkg::SPIMSP_IDLE;
          end
        end
        default: begin
          state_q <= spimsp_pkg::SPIMSP_IDLE;
        end
      endcase
    end
  end

  // pins, released while the i2c unit owns them
  assign sclk_o    = sclk_q;
  assign mosi_o    = sh_q[7];
  assign miso_o    = sh_q[7];
  assign sclk_oe_o = m_act;
  assign mosi_oe_o = m_act;
  assign sel_oe_o  = m_act;
  assign miso_oe_o = s_act;
  assign sel_n_o   = ~m_act | (auto_sel & ~in_shift);
  assign irq_o     = irq_cond;
  assign prdata_o  = prdata_q;
  assign pready_o  = rdy_q;
  assign pslverr_o = rdy_q & ~mapped;

  // checks
  sequence wr_tx_s;
    wr & hit_tx;
  endsequence

  sequence rise_hold4_s;
    sclk_o [*4] ##1 !sclk_o;
  endsequence

  sel_manual_a: assert property (m_act && !auto_sel |-> !sel_n_o)
    else $error("select not low under manual control");
  sel_single_a: assert property (m_act && auto_sel && byte_done && !cont
                                 |=> !in_shift && sel_n_o)
    else $error("select not raised after single byte");
  sel_cont_a: assert property (m_act && auto_sel && m_next
                               ##1 m_act && auto_sel |-> !sel_n_o)
    else $error("select dropped inside continuous run");
  rx_keep_a: assert property (drop && !ovf_write |=> rx_hold_q == $past(rx_hold_q) && ovf_q)
    else $error("old byte lost with overflow write clear");
  rx_replace_a: assert property (drop && ovf_write |=> rx_hold_q == $past(rx_byte))
    else $error("old byte not replaced with overflow write set");
  tx_push_a: assert property (wr_tx_s |=> tx_full_q && tx_hold_q == $past(pwdata_i[7:0]))
    else $error("tx write not held");
  rx_pop_a: assert property (rx_full_q && rd && hit_rx && !rx_fresh_q && !byte_done
                             |=> !rx_full_q)
    else $error("rx read did not pop");
  irq_mode_a: assert property (en && !irq_mode && $rose(rx_full_q) |-> irq_o)
    else $error("irq missing on rx full");
  irq_hold_a: assert property (irq_o && !irq_mode && !pop ##1 en && !irq_mode |-> irq_o)
    else $error("irq dropped before service");
  rate_zero_a: assert property (m_act && rate == 2'b00 && $rose(sclk_o) |-> rise_hold4_s)
    else $error("sclk high phase not four cycles at rate zero");
  owner_a: assert property (owner_q |-> !sclk_oe_o && !mosi_oe_o && !miso_oe_o && !sel_oe_o)
    else $error("pins driven while i2c owns them");
  slave_gate_a: assert property (!m_act && sel_in_en && sel_n_s |=> cnt_q == spimsp_pkg::FIRST_BIT)
    else $error("slave counted bits while deselected");
  byte_len_a: assert property (m_start |-> ##1 in_shift [*8])
    else $error("master left shift early");

endmodule : spimsp_port

// ==== inc/spimsp_pkg.sv ====
// constants, register map and types of the serial master/slave port
package spimsp_pkg;
  // apb byte address width; register index times four is the byte address
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_TX_BUF    = 8'h9a;
  localparam logic [7:0] IDX_RX_BUF    = 8'h9b;
  localparam logic [7:0] IDX_CFG_ONE   = 8'he8;
  localparam logic [7:0] IDX_CFG_TWO   = 8'he9;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hea;
  localparam logic [7:0] IDX_PIN_OWNER = 8'heb;
  // reset values
  localparam logic [7:0] CFG_ONE_RST   = 8'h10;
  localparam logic [7:0] CFG_TWO_RST   = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  // serial_config_one fields
  localparam int unsigned C1_IRQ_MODE  = 5;
  localparam int unsigned C1_AUTO_SEL  = 4;
  localparam int unsigned C1_SEL_IN_EN = 3;
  localparam int unsigned C1_OVF_WRITE = 2;
  localparam int unsigned C1_RATE_HI   = 1;
  localparam int unsigned C1_RATE_LO   = 0;
  // serial_config_two fields
  localparam int unsigned C2_CONT      = 7;
  localparam int unsigned C2_ENABLE    = 6;
  localparam int unsigned C2_MASTER    = 4;
  // serial_irq_status fields
  localparam int unsigned ST_RX_FULL   = 0;
  localparam int unsigned ST_TX_EMPTY  = 1;
  localparam int unsigned ST_BUSY      = 2;
  localparam int unsigned ST_OVERFLOW  = 3;
  localparam int unsigned ST_IRQ       = 4;
  // pin owner register field
  localparam int unsigned OWN_I2C      = 0;
  // sclk half period for rate code 00 (divide by 8), doubled per code step
  localparam logic [5:0] HALF_BASE     = 6'h04;
  localparam logic [5:0] HALF_ZERO     = 6'h00;
  // sclk half periods that select stays high between single bytes
  localparam logic [3:0] STALL_HALVES  = 4'h2;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [2:0] FIRST_BIT     = 3'h0;
  // master sequencer, gray coded along idle, shift, stall
  typedef enum logic [1:0] {
    SPIMSP_IDLE  = 2'b00,
    SPIMSP_SHIFT = 2'b01,
    SPIMSP_STALL = 2'b11
  } spimsp_state_t;
endpackage : spimsp_pkg

// ==== sim/spimsp_slave_model.sv ====
// behavioural external serial slave device, mode 0, msb first
`timescale 1ns/1ps
module spimsp_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [7:0] out_q;
  logic [7:0] in_q;
  logic [2:0] nbits_q;
  // quiet start; the bench resolves the line while deselected
  initial begin
    miso_o = 1'b1;
    rx_o = 8'h00;
    nbits_q = 3'h0;
  end
  // load the reply byte and present its msb when selected
  always @(negedge sel_n_i) begin
    out_q = tx_i;
    miso_o = tx_i[7];
    nbits_q = 3'h0;
  end
  // sample master data on the rising edge, keep each whole byte
  always @(posedge sclk_i) begin
    if (!sel_n_i) begin
      in_q = {in_q[6:0], mosi_i};
      nbits_q = nbits_q + 3'h1;
      if (nbits_q == 3'h0) begin
        rx_o = in_q;
      end
    end
  end
  // next bit after the falling edge; reload the reply between bytes
  always @(negedge sclk_i) begin
    if (!sel_n_i) begin
      out_q = (nbits_q == 3'h0) ? tx_i : {out_q[6:0], 1'b0};
      miso_o = out_q[7];
    end
  end
endmodule : spimsp_slave_model

// ==== sim/tb_top.sv ====
// self-checking bench of the serial port in master and slave mode
`timescale 1ns/1ps
module tb_top;
  logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, sel_n, sel_oe, irq;
  logic        sclk_w, mosi_w, miso_w, sel_w, m_miso, sclk_d, sel_d;
  logic        ext_sclk, ext_mosi, ext_sel;
  logic [7:0]  m_tx, m_rx, rd;
  int          failures, n_checks, cnt, period, rises, sel_rises;
  // pins with pull-ups: released lines float high
  // the bench's external master idles at the pull-up level
  assign sclk_w = sclk_oe ? sclk : ext_sclk;
  assign mosi_w = mosi_oe ? mosi : ext_mosi;
  assign sel_w  = sel_oe ? sel_n : ext_sel;
  assign miso_w = miso_oe ? miso : (sel_w ? 1'b1 : m_miso);
  spimsp_port uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sclk_i(sclk_w), .sclk_o(sclk),
    .sclk_oe_o(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
    .miso_i(miso_w), .miso_o(miso), .miso_oe_o(miso_oe), .sel_n_i(sel_w),
    .sel_n_o(sel_n), .sel_oe_o(sel_oe), .irq_o(irq));
  spimsp_slave_model peer (.sclk_i(sclk_w), .mosi_i(mosi_w), .sel_n_i(sel_w),
    .tx_i(m_tx), .miso_o(m_miso), .rx_o(m_rx));
  // clock edge counts, last clock period and select releases
  always @(posedge clk_i) begin
    sclk_d <= sclk;
    sel_d <= sel_n;
    cnt <= cnt + 1;
    if (sclk === 1'b1 && sclk_d === 1'b0) begin
      period <= cnt;
      cnt <= 1;
      rises <= rises + 1;
    end
    if (sel_n === 1'b1 && sel_d === 1'b0) begin
      sel_rises <= sel_rises + 1;
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // one apb transfer; waits for pready with a bound
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(pready, 1'b1);
      give_verdict();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rchk
  // wait for tgt clocks, eight a byte, the select release, then the stall
  task wait_done(input int tgt, input int r, input logic auto_sel);
    int i;
    for (i = 0; i < 4000 && (rises < tgt || (auto_sel && sel_n !== 1'b1)); i++) begin
      @(posedge clk_i);
    end
    chk(rises, tgt);
    if (i >= 4000) begin
      give_verdict();
    end
    repeat ((8 << r) + 4) @(posedge clk_i);
  endtask : wait_done
  task xfer(input logic [7:0] tx, input logic [7:0] reply, input int r, input logic auto_sel);
    int b;
    int s;
    m_tx = reply;
    b = rises;
    s = sel_rises;
    apb(1'b1, spimsp_pkg::IDX_TX_BUF, tx);
    wait_done(b + 8, r, auto_sel);
    chk(m_rx, tx);
    chk(sel_rises, s + (auto_sel ? 1 : 0));
  endtask : xfer
  task s_reset;
    rchk(spimsp_pkg::IDX_CFG_ONE, 8'h10);
    rchk(spimsp_pkg::IDX_CFG_TWO, 8'h00);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk(err, 1'b1);
    chk(sclk_oe, 1'b0);
  endtask : s_reset
  task s_rates;
    apb(1'b1, spimsp_pkg::IDX_CFG_TWO, 8'h50);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h10 | r[7:0]);
      xfer(8'ha5 ^ r[7:0], 8'h3c + r[7:0], r, 1'b1);
      chk(period, 8 << r);
      rchk(spimsp_pkg::IDX_RX_BUF, 8'h3c + r[7:0]);
    end
  endtask : s_rates
  task s_ovf_irq;
    int b;
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h10);
    xfer(8'h01, 8'h11, 0, 1'b1);
    xfer(8'h02, 8'h22, 0, 1'b1);
    chk(irq, 1'b1);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'h11);
    @(negedge clk_i);
    chk(irq, 1'b0);
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h14);
    xfer(8'h03, 8'h33, 0, 1'b1);
    xfer(8'h04, 8'h44, 0, 1'b1);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'h44);
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h30);
    @(negedge clk_i);
    chk(irq, 1'b1);
    apb(1'b1, spimsp_pkg::IDX_CFG_TWO, 8'h10);
    m_tx = 8'h55;
    b = rises;
    apb(1'b1, spimsp_pkg::IDX_TX_BUF, 8'h77);
    repeat (40) @(posedge clk_i);
    chk(rises, b);
    chk(sclk_oe, 1'b0);
    apb(1'b1, spimsp_pkg::IDX_CFG_TWO, 8'h50);
    wait_done(b + 8, 0, 1'b1);
    chk(m_rx, 8'h77);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'h55);
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h10);
  endtask : s_ovf_irq
  task s_cont;
    int b;
    int s;
    apb(1'b1, spimsp_pkg::IDX_CFG_TWO, 8'hd0);
    m_tx = 8'h66;
    b = rises;
    s = sel_rises;
    apb(1'b1, spimsp_pkg::IDX_TX_BUF, 8'h5a);
    apb(1'b1, spimsp_pkg::IDX_TX_BUF, 8'hc3);
    wait_done(b + 16, 0, 1'b1);
    chk(sel_rises, s + 1);
    chk(m_rx, 8'hc3);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'h66);
  endtask : s_cont
  task s_manual;
    int s;
    apb(1'b1, spimsp_pkg::IDX_CFG_TWO, 8'h50);
    m_tx = 8'h12;
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h00);
    @(negedge clk_i);
    chk(sel_n, 1'b0);
    s = sel_rises;
    xfer(8'h99, 8'h12, 0, 1'b0);
    chk(sel_n, 1'b0);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'h12);
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h10);
  endtask : s_manual
  task s_modes;
    apb(1'b1, spimsp_pkg::IDX_PIN_OWNER, 8'h01);
    @(negedge clk_i);
    chk(sclk_oe, 1'b0);
    apb(1'b1, spimsp_pkg::IDX_PIN_OWNER, 8'h00);
    @(negedge clk_i);
    chk(sclk_oe, 1'b1);
    apb(1'b1, spimsp_pkg::IDX_CFG_TWO, 8'h40);
    @(negedge clk_i);
    chk(sclk_oe, 1'b0);
  endtask : s_modes
  // external master byte: mode 0, msb first, eight core cycles a half period
  task ext_byte(input logic [7:0] tx, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      ext_mosi <= tx[i];
      repeat (8) @(posedge clk_i);
      ext_sclk <= 1'b1;
      got[i] = miso_w;
      repeat (8) @(posedge clk_i);
      ext_sclk <= 1'b0;
    end
  endtask : ext_byte
  // slave mode with select input enabled; the bench plays the master
  task s_slave;
    logic [7:0] got;
    apb(1'b1, spimsp_pkg::IDX_CFG_ONE, 8'h18);
    apb(1'b1, spimsp_pkg::IDX_TX_BUF, 8'h6b);
    ext_sclk <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(miso_oe, 1'b0);
    ext_sel <= 1'b0;
    ext_byte(8'ha9, got);
    repeat (8) @(posedge clk_i);
    ext_sel <= 1'b1;
    chk(got, 8'h6b);
    chk(irq, 1'b1);
    rchk(spimsp_pkg::IDX_RX_BUF, 8'ha9);
    ext_byte(8'h3c, got);
    repeat (8) @(posedge clk_i);
    chk(irq, 1'b0);
  endtask : s_slave
  // reset, then the scenarios in turn
  initial begin
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    m_tx = 8'h00;
    ext_sclk = 1'b1;
    ext_mosi = 1'b1;
    ext_sel = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_reset();
    s_rates();
    s_ovf_irq();
    s_cont();
    s_manual();
    s_modes();
    s_slave();
    give_verdict();
  end
endmodule : tb_top
